/* File: core/ipc_pkg.sv */
// Constants and carrier types of the interrupt priority controller
// Functional notes
// - Six sources with own vectors: ext 0, ext 1, timers 0-2, serial.
// - A source whose enable bit is clear is never serviced.
// - Global enable bit 7 clear blocks all; set defers to source bits.
// - Enable register at index A8h: t2 b5, ser b4, t1 b3, x1 b2, t0 b1, x0 b0.
// - Enable register resets to zero, global and source enables clear.
// - Level is {high bit, low bit}: 00 lowest up to 11 highest.
// - Low level-select register at index B8h, same bit layout.
// - High level-select register at index B7h, same bit layout.
// - Only a strictly higher level preempts a service in progress.
// - A level 3 service is never preempted.
// - Of simultaneous requests the higher level is granted.
// - Equal-level requests are resolved by a fixed polling order.
// - Serial request is the OR of tx and rx done flags, cleared by sw.
// - An enabled active request clears the idle bit to wake the core.
package ipc_pkg;

    localparam int NSRC = 6;
    localparam int NEV = 3;
    localparam int AW = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ENA_IDX = 8'hA8;
    localparam logic [7:0] LVH_IDX = 8'hB7;
    localparam logic [7:0] IPL_IDX = 8'hB8;
    localparam logic [7:0] PWR_IDX = 8'h87;
    localparam logic [7:0] SFLG_IDX = 8'hC0;
    localparam logic [7:0] ISTS_IDX = 8'hC1;
    localparam logic [7:0] IMSK_IDX = 8'hC2;
    localparam logic [7:0] SVC_IDX = 8'hC3;

    // Source bit positions, also the polling order
    localparam int SRC_X0 = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_X1 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_SER = 4;
    localparam int SRC_T2 = 5;
    localparam int GEN_BIT = 7;

    localparam logic [7:0] ENA_WMASK = 8'hBF;
    localparam logic [7:0] ENA_RST = 8'h00;
    localparam logic [5:0] LVL_RST = 6'h00;

    localparam int TXF_BIT = 1;
    localparam int RXF_BIT = 0;
    localparam int IDLE_BIT = 0;

    // Event status bits
    localparam int EV_GRANT = 0;
    localparam int EV_PREEMPT = 1;
    localparam int EV_WAKE = 2;

    typedef struct packed {
        logic req;
        logic [2:0] vec;
        logic [1:0] lvl;
    } ipc_offer_s;

    typedef struct packed {
        logic [1:0] ext_meta;
        logic [1:0] ext_sync;
        logic [7:0] ena;
        logic [5:0] lvh;
        logic [5:0] ipl;
        logic tx_done;
        logic rx_done;
        logic idle;
        logic [NEV-1:0] sts;
        logic [NEV-1:0] msk;
        logic [3:0] in_svc;
        ipc_offer_s offer;
        logic [31:0] rdata;
        logic err;
    } ipc_state_s;

endpackage : ipc_pkg

/* File: core/ipc_top.sv */
// Interrupt priority controller with APB register access
`timescale 1ns/1ps
module ipc_top
    import ipc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Request sources
    input wire logic ext_request_0,
    input wire logic ext_request_1,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic tx_done_set,
    input wire logic rx_done_set,

    // Core sequencer
    output ipc_offer_s offer,
    input wire logic cpu_ack,
    input wire logic cpu_reti,
    output logic idle_mode,

    // Event interrupt
    output logic irq
);

    ipc_state_s q;
    ipc_state_s d;

    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] req_w;
    logic setup;
    logic wr;

    // Highest level currently in service
    function automatic logic [1:0] top_lvl(input logic [3:0] svc);
        logic [1:0] cur;
        cur = 2'b00;
        for (int k = 0; k < 4; k++) begin
            if (svc[k]) begin
                cur = 2'(k);
            end
        end
        return cur;
    endfunction : top_lvl

    // Highest level wins; at equal level the lower bit index wins
    function automatic ipc_offer_s arbitrate(
        input logic [NSRC-1:0] r,
        input logic [NSRC-1:0] h,
        input logic [NSRC-1:0] l,
        input logic [3:0] svc
    );
        ipc_offer_s o;
        logic [1:0] lv;
        o = '0;
        lv = 2'b00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            lv = {h[i], l[i]};
            if (r[i] && (!o.req || lv >= o.lvl)) begin
                o.req = 1'b1;
                o.vec = 3'(i);
                o.lvl = lv;
            end
        end
        if (|svc && o.lvl <= top_lvl(svc)) begin
            o.req = 1'b0;
        end
        return o;
    endfunction : arbitrate

    // Source vector in polling order
    always_comb begin
        pend = '0;
        pend[SRC_X0] = q.ext_sync[0];
        pend[SRC_T0] = timer0_ovf;
        pend[SRC_X1] = q.ext_sync[1];
        pend[SRC_T1] = timer1_ovf;
        pend[SRC_SER] = q.tx_done | q.rx_done;
        pend[SRC_T2] = timer2_ovf;
    end

    assign req_w = pend & q.ena[NSRC-1:0] & {NSRC{q.ena[GEN_BIT]}};

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;

    always_comb begin
        logic [3:0] svc;
        logic [NEV-1:0] ev;
        logic [7:0] idx;
        logic [31:0] rd;
        logic hit;
        d = q;
        svc = q.in_svc;
        ev = '0;
        idx = paddr[AW-1:2];
        rd = '0;
        hit = (paddr[1:0] == 2'b00);

        // Pin synchroniser
        d.ext_meta = {ext_request_1, ext_request_0};
        d.ext_sync = q.ext_meta;

        // Return first, then acceptance of a new vector
        if (cpu_reti && |svc) begin
            svc[top_lvl(svc)] = 1'b0;
        end
        if (cpu_ack && q.offer.req) begin
            ev[EV_GRANT] = 1'b1;
            ev[EV_PREEMPT] = |svc;
            svc[q.offer.lvl] = 1'b1;
        end
        d.in_svc = svc;
        d.offer = arbitrate(req_w, q.lvh, q.ipl, svc);

        // Register writes
        if (wr && paddr[1:0] == 2'b00) begin
            case (idx)
                ENA_IDX: begin
                    d.ena = pwdata[7:0] & ENA_WMASK;
                end
                LVH_IDX: begin
                    d.lvh = pwdata[NSRC-1:0];
                end
                IPL_IDX: begin
                    d.ipl = pwdata[NSRC-1:0];
                end
                PWR_IDX: begin
                    d.idle = pwdata[IDLE_BIT];
                end
                SFLG_IDX: begin
                    d.tx_done = pwdata[TXF_BIT];
                    d.rx_done = pwdata[RXF_BIT];
                end
                ISTS_IDX: begin
                    d.sts = q.sts & ~pwdata[NEV-1:0];
                end
                IMSK_IDX: begin
                    d.msk = pwdata[NEV-1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware flag sets win over a software clear
        if (tx_done_set) begin
            d.tx_done = 1'b1;
        end
        if (rx_done_set) begin
            d.rx_done = 1'b1;
        end

        // Wake wins over a software idle request in the same cycle
        if (|req_w) begin
            ev[EV_WAKE] = q.idle;
            d.idle = 1'b0;
        end
        d.sts = d.sts | ev;

        // Read data captured in the setup phase
        case (idx)
            ENA_IDX: begin
                rd[7:0] = q.ena;
            end
            LVH_IDX: begin
                rd[NSRC-1:0] = q.lvh;
            end
            IPL_IDX: begin
                rd[NSRC-1:0] = q.ipl;
            end
            PWR_IDX: begin
                rd[IDLE_BIT] = q.idle;
            end
            SFLG_IDX: begin
                rd[TXF_BIT] = q.tx_done;
                rd[RXF_BIT] = q.rx_done;
            end
            ISTS_IDX: begin
                rd[NEV-1:0] = q.sts;
            end
            IMSK_IDX: begin
                rd[NEV-1:0] = q.msk;
            end
            SVC_IDX: begin
                rd[3:0] = q.in_svc;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (setup) begin
            d.rdata = hit ? rd : 32'h00000000;
            d.err = ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & q.err;
    assign offer = q.offer;
    assign idle_mode = q.idle;
    assign irq = |(q.sts & q.msk);

    // Checking helpers
    logic [1:0] req_max;
    logic [1:0] act_lvl;

    always_comb begin
        req_max = 2'b00;
        for (int i = 0; i < NSRC; i++) begin
            if (req_w[i] && {q.lvh[i], q.ipl[i]} > req_max) begin
                req_max = {q.lvh[i], q.ipl[i]};
            end
        end
    end

    assign act_lvl = top_lvl(q.in_svc);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    enable_gate_a: assert property (
        offer.req |-> |($past(q.ena[NSRC-1:0]) & (6'h01 << offer.vec)))
        else $error("offer made for a disabled source");

    global_gate_a: assert property (
        offer.req |-> $past(q.ena[GEN_BIT]))
        else $error("offer made with global enable clear");

    enable_reset_a: assert property (
        !$past(presetn) |-> q.ena == ENA_RST && q.ipl == LVL_RST)
        else $error("enable register not zero after reset");

    top_level_a: assert property (
        q.in_svc[3] && !cpu_reti |=> !offer.req)
        else $error("offer made during a level 3 service");

    preempt_higher_a: assert property (
        offer.req && |q.in_svc |-> offer.lvl > act_lvl)
        else $error("preemption by a level not strictly higher");

    higher_first_a: assert property (
        offer.req |-> offer.lvl == $past(req_max))
        else $error("granted level is not the highest requested");

    idle_wake_a: assert property (
        q.idle && |req_w |=> !q.idle && q.sts[EV_WAKE])
        else $error("enabled request did not end idle");

    serial_set_a: assert property (
        tx_done_set |=> q.tx_done && pend[SRC_SER])
        else $error("tx done set lost or not requesting");

endmodule : ipc_top

/* File: testbench/ipc_cpu_model.sv */
// Core sequencer model that takes offered vectors and returns from them
`timescale 1ns/1ps
module ipc_cpu_model
    import ipc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controller offer and bench controls
    input wire ipc_offer_s offer,
    input wire logic hold,
    input wire logic ret,
    // Core answers
    output logic cpu_ack,
    output logic cpu_reti
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_reti <= 1'b0;
        end else begin
            // One pulse per standing offer; hold keeps it from answering
            cpu_ack <= offer.req && !cpu_ack && !hold;
            cpu_reti <= ret;
        end
    end
endmodule : ipc_cpu_model

/* File: testbench/tb_interrupt_priority_ctrl.sv */
// Self-checking bench of the interrupt priority controller
`timescale 1ns/1ps
module tb_interrupt_priority_ctrl
    import ipc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, idle_mode, cpu_ack, cpu_reti;
    logic [5:0] src = 6'h00;
    logic tx_set = 0, rx_set = 0, hold = 0, ret = 0;
    logic [2:0] got_vec;
    ipc_offer_s offer;
    int err_total = 0, checked = 0, cyc = 0, exp_q[$];

    always #2 pclk = ~pclk;

    ipc_top ipc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_request_0(src[0]), .ext_request_1(src[2]),
        .timer0_ovf(src[1]), .timer1_ovf(src[3]), .timer2_ovf(src[5]),
        .tx_done_set(tx_set), .rx_done_set(rx_set), .offer, .cpu_ack,
        .cpu_reti, .idle_mode, .irq);
    ipc_cpu_model ipc_cpu_model_inst (.pclk, .presetn, .offer, .hold,
        .ret, .cpu_ack, .cpu_reti);

    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task end_sim;
        $display("err_total=%0d checked=%0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task apb(input logic w, input logic [9:0] a, input logic [31:0] d, e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk(32'(pslverr), 32'(a == 10'h3FC));
        if (!w) chk(prdata, e);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task raise(input logic [5:0] m);
        logic r;
        r = 1'($urandom);
        @(posedge pclk);
        src <= src | (m & 6'h2F);
        tx_set <= m[4] & r;
        rx_set <= m[4] & !r;
        @(posedge pclk);
        tx_set <= 1'b0;
        rx_set <= 1'b0;
    endtask : raise

    task drop(input logic [2:0] v);
        if (v == 3'h4) begin
            apb(1'b1, 10'h300, 32'h0, 32'h0);
        end else begin
            @(posedge pclk);
            src[v] <= 1'b0;
        end
    endtask : drop

    task wait_ack;
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!(cpu_ack === 1'b1 && offer.req === 1'b1) && k < 80);
        chk(32'(k < 80), 32'h1);
        got_vec = offer.vec;
    endtask : wait_ack

    task retire(input logic [2:0] v);
        drop(v);
        repeat (5) @(posedge pclk);
        ret <= 1'b1;
        @(posedge pclk);
        ret <= 1'b0;
    endtask : retire

    task set_lv(input logic [11:0] lv);
        logic [31:0] hi, lo;
        hi = 32'h0;
        lo = 32'h0;
        for (int i = 0; i < 6; i++) begin
            hi[i] = lv[2*i+1];
            lo[i] = lv[2*i];
        end
        apb(1'b1, 10'h2DC, hi, 32'h0);
        apb(1'b1, 10'h2E0, lo, 32'h0);
        apb(1'b0, 10'h2DC, 32'h0, hi);
        apb(1'b0, 10'h2E0, 32'h0, lo);
    endtask : set_lv

    // Bit 6 stays zero in every enable write
    task round(input logic [11:0] lv, input logic [5:0] en);
        apb(1'b1, 10'h2A0, {24'h0, 2'b10, en}, 32'h0);
        set_lv(lv);
        for (int l = 3; l >= 0; l--)
            for (int i = 0; i < 6; i++)
                if (en[i] && lv[2*i+:2] == l) exp_q.push_back(i);
        hold <= 1'b1;
        raise(6'h3F);
        repeat (5) @(posedge pclk);
        hold <= 1'b0;
        repeat ($countones(en)) begin
            wait_ack;
            retire(got_vec);
        end
        src <= 6'h00;
        apb(1'b1, 10'h300, 32'h0, 32'h0);
    endtask : round

    task pre(input logic [1:0] la, lb);
        set_lv({4'h0, lb, 2'b00, la, 2'b00});
        exp_q.push_back(1);
        raise(6'h02);
        wait_ack;
        if (lb > la) exp_q.push_back(3);
        raise(6'h08);
        repeat (15) @(posedge pclk);
        chk(exp_q.size(), 32'h0);
        apb(1'b0, 10'h30C, 32'h0,
            32'((4'h1 << la) | ((lb > la) ? (4'h1 << lb) : 4'h0)));
        if (lb > la) retire(3);
        else drop(3);
        retire(1);
    endtask : pre

    always @(posedge pclk)
        if (presetn && cpu_ack === 1'b1 && offer.req === 1'b1) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk(32'(offer.vec), exp_q.pop_front());
        end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim;
        end
    end

    initial begin
        void'($urandom(20));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 10'h2A0, 32'h0, 32'h0);
        apb(1'b0, 10'h2DC, 32'h0, 32'h0);
        apb(1'b0, 10'h3FC, 32'h0, 32'h0);
        apb(1'b1, 10'h2A0, 32'h3F, 32'h0);
        raise(6'h3F);
        repeat (20) @(posedge pclk);
        chk(32'(offer.req), 32'h0);
        src <= 6'h00;
        apb(1'b1, 10'h300, 32'h0, 32'h0);
        round(12'h000, 6'h2A);
        round(12'h000, 6'h3F);
        round(12'hFFF, 6'h3F);
        repeat (3) round(12'($urandom), 6'h3F);
        pre(2'd1, 2'd2);
        pre(2'd1, 2'd1);
        pre(2'd2, 2'd1);
        pre(2'd3, 2'd3);
        apb(1'b1, 10'h21C, 32'h1, 32'h0);
        apb(1'b0, 10'h21C, 32'h0, 32'h1);
        chk(32'(idle_mode), 32'h1);
        exp_q.push_back(5);
        raise(6'h20);
        wait_ack;
        chk(32'(idle_mode), 32'h0);
        retire(5);
        apb(1'b0, 10'h304, 32'h0, 32'h7);
        chk(32'(irq), 32'h0);
        apb(1'b1, 10'h308, 32'h2, 32'h0);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, 10'h304, 32'h7, 32'h0);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        apb(1'b0, 10'h304, 32'h0, 32'h0);
        chk(exp_q.size(), 32'h0);
        end_sim;
    end
endmodule : tb_interrupt_priority_ctrl
